// File: sfa_pkg.sv
package sfa_pkg;

  localparam int SFA_CH         = 8;
  localparam int SFA_COLS       = 1080;
  localparam int SFA_ROWS       = 9;
  localparam int SFA_A1_N       = 12;
  localparam int SFA_SCR_COL    = 36;
  localparam int SFA_B1_ROW     = 1;
  localparam int SFA_CONFIRM_N  = 4;
  localparam int SFA_SKEW_MAX   = 18;
  localparam int SFA_READ_WAIT  = 9;
  localparam int SFA_FIFO_DEPTH = 32;
  localparam int SFA_WORD_W     = 10;

  localparam logic [7:0] SFA_A1   = 8'hF6;
  localparam logic [7:0] SFA_A2   = 8'h28;
  localparam logic [7:0] SFA_ONES = 8'hFF;
  localparam logic [6:0] SFA_SEED = 7'h7F;

  // sts-3 oversampling: four copies per bit, one byte out per four in
  localparam logic [1:0] SFA_SAMP_LAST = 2'h3;
  localparam int         SFA_SAMP_HI   = 7;
  localparam int         SFA_SAMP_LO   = 3;

  localparam logic [19:0] SFA_OFS_THR_MIN  = 20'h3000A;
  localparam logic [19:0] SFA_OFS_THR_MAX  = 20'h3000B;
  localparam logic [19:0] SFA_OFS_CTRL     = 20'h3000C;
  localparam logic [19:0] SFA_OFS_ALIGN    = 20'h30010;
  localparam logic [19:0] SFA_OFS_CH_EN    = 20'h30011;
  localparam logic [19:0] SFA_OFS_OOF_STAT = 20'h30012;
  localparam logic [19:0] SFA_OFS_THR_ALM  = 20'h30013;
  localparam logic [19:0] SFA_OFS_OOS_ALM  = 20'h30014;
  localparam logic [19:0] SFA_OFS_OOF_ALM  = 20'h30015;
  localparam logic [19:0] SFA_OFS_FRM_ERR  = 20'h30020;
  localparam logic [19:0] SFA_OFS_B1_ERR   = 20'h30028;

  localparam logic [7:0] SFA_THR_MIN_RST = 8'h02;
  localparam logic [7:0] SFA_THR_MAX_RST = 8'h0F;
  localparam logic [7:0] SFA_CTRL_RST    = 8'h00;
  localparam logic [7:0] SFA_CH_EN_RST   = 8'hFF;

  localparam int SFA_CTRL_STS3   = 0;
  localparam int SFA_CTRL_BYPASS = 1;
  localparam int SFA_CTRL_FAIS   = 2;
  localparam int SFA_CTRL_AISOOF = 3;
  localparam int SFA_ALIGN_RESYNC = 2;

  typedef enum logic [1:0] {
    SFA_OOF  = 2'b00,
    SFA_CONF = 2'b01,
    SFA_INF  = 2'b10,
    SFA_ERR  = 2'b11
  } sfa_frm_state_t;

  typedef enum logic [1:0] {
    SFA_GRP_NONE = 2'b00,
    SFA_GRP_PAIR = 2'b01,
    SFA_GRP_QUAD = 2'b10,
    SFA_GRP_ALL  = 2'b11
  } sfa_grp_mode_t;

  typedef enum logic [1:0] {
    SFA_AL_WAIT = 2'b00,
    SFA_AL_RUN  = 2'b01,
    SFA_AL_OOS  = 2'b10
  } sfa_al_state_t;

  typedef struct packed {
    logic       in_frame;
    logic       fp;
    logic [7:0] data;
  } sfa_word_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } sfa_reg_req_t;

endpackage : sfa_pkg

// File: sfa_frame_align.sv
// Functional notes
// - sts-3 mode folds quadruple bits into bytes
// - frame pulse with first A1 byte
// - reset into OOF, search A1 on every sampled byte
// - A1/A2 found: confirm, lock offset, load counters
// - counters loaded only on OOF to confirm
// - confirm checks only at predicted position
// - in-frame after four consecutive good patterns
// - in-frame miss goes errored; data valid in-frame
// - second miss goes OOF with alarm
// - errored frames counted, bus readable
// - BIP-8 before descrambling, checked next B1
// - B1 counter adds each mismatched bit
// - 1+x6+x7 descrambler with bypass bit
// - A1, A2, J0, Z0 bytes not descrambled
// - forced AIS makes every byte ones
// - AIS on OOF when enabled
// - AIS inserted after overhead and B1 taps
// - alignment FIFO does write-to-read transfer
// - ten-bit words, absorbs eighteen cycles skew
// - min/max fill thresholds raise two alarms
// - groups of two, four or eight
// - disabled streams silent, rejoin rules
// - failed channel is never dropped from its group; realign passes nothing
// - late frame pulse past eighteen: out of sync

module sfa_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_sys_in,
  input  wire logic         reset_n_in,
  input  wire logic         flush_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  input  wire logic         out_ready_in,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];
  assign level_out     = cnt_q;
  assign cnt_d = flush_in ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || flush_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      cnt_q        <= '0;
      in_ready_out <= 1'b0;
    end else begin
      cnt_q        <= cnt_d;
      in_ready_out <= (cnt_d < (AW+1)'(DEPTH));
    end
  end
endmodule : sfa_fifo

module sfa_chan
  import sfa_pkg::*;
(
  input  wire logic  clk_sys_in,
  input  wire logic  reset_n_in,
  input  wire logic  valid_in,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] ctrl_in,
  output sfa_word_t  word_out,
  output logic       word_valid_out,
  output logic       oof_out,
  output logic       oof_entry_out,
  output logic [7:0] frm_err_out,
  output logic [7:0] b1_err_out
);
  sfa_frm_state_t st_q;
  logic [1:0]  samp_ph_q, conf_q, seen_q;
  logic [7:0]  samp_acc_q, prev_raw_q, prev_al_q, hit_a1_q, trans, bip_q,
               bip_prev_q, s_data, aligned, descr, mism;
  logic [15:0] win;
  logic [2:0]  off_q, find_k;
  logic        s_valid, found, at_check, check_ok, at_fp, at_b1, scr_en, ais;
  logic [10:0] col_q;
  logic [3:0]  row_q;
  logic [6:0]  lfsr_q, seed;
  logic [14:0] step;

  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [6:0] t;
    logic [7:0] k;
    t = s;
    k = '0;
    for (int i = 7; i >= 0; i--) begin
      k[i] = t[6];
      t    = {t[5:0], t[6] ^ t[5]};
    end
    return {k, t};
  endfunction : scr_step

  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction : ones

  // sampler
  assign s_valid = valid_in &
                   (!ctrl_in[SFA_CTRL_STS3] || samp_ph_q == SFA_SAMP_LAST);
  assign s_data  = ctrl_in[SFA_CTRL_STS3] ?
                   {samp_acc_q[5:0], data_in[SFA_SAMP_HI], data_in[SFA_SAMP_LO]}
                   : data_in;

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      samp_ph_q  <= '0;
      samp_acc_q <= '0;
    end else if (valid_in) begin
      samp_ph_q  <= samp_ph_q + 2'(1);
      samp_acc_q <= {samp_acc_q[5:0], data_in[SFA_SAMP_HI],
                     data_in[SFA_SAMP_LO]};
    end
  end

  // byte search over all eight bit offsets
  assign win = {prev_raw_q, s_data};
  always_comb begin
    trans  = '0;
    found  = 1'b0;
    find_k = '0;
    for (int k = 0; k < 8; k++) begin
      trans[k] = hit_a1_q[k] && (win[15-k -: 8] == SFA_A2);
    end
    for (int k = 7; k >= 0; k--) begin
      if (trans[k]) begin
        found  = 1'b1;
        find_k = 3'(k);
      end
    end
  end
  assign aligned  = win[15-off_q -: 8];
  assign at_check = (row_q == '0) && (col_q == 11'(SFA_A1_N));
  assign check_ok = (aligned == SFA_A2) && (prev_al_q == SFA_A1);
  assign at_fp    = (row_q == '0) && (col_q == '0);
  assign at_b1    = (row_q == 4'(SFA_B1_ROW)) && (col_q == '0);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      prev_raw_q <= '0;
      prev_al_q  <= '0;
      hit_a1_q   <= '0;
    end else if (s_valid) begin
      prev_raw_q <= s_data;
      prev_al_q  <= aligned;
      for (int k = 0; k < 8; k++) begin
        hit_a1_q[k] <= (win[15-k -: 8] == SFA_A1);
      end
    end
  end

  // framer state, offset lock and row/column counters
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_q   <= SFA_OOF;
      off_q  <= '0;
      conf_q <= '0;
      col_q  <= '0;
      row_q  <= '0;
    end else if (s_valid) begin
      if (st_q == SFA_OOF && found) begin
        off_q <= find_k;
        col_q <= 11'(SFA_A1_N + 1);
        row_q <= '0;
      end else if (col_q == 11'(SFA_COLS - 1)) begin
        col_q <= '0;
        row_q <= (row_q == 4'(SFA_ROWS - 1)) ? '0 : row_q + 4'(1);
      end else begin
        col_q <= col_q + 11'(1);
      end
      case (st_q)
        SFA_OOF: begin
          if (found) begin
            st_q   <= SFA_CONF;
            conf_q <= 2'(1);
          end
        end
        SFA_CONF: begin
          if (at_check) begin
            if (!check_ok) begin
              st_q <= SFA_OOF;
            end else if (conf_q == 2'(SFA_CONFIRM_N - 1)) begin
              st_q <= SFA_INF;
            end else begin
              conf_q <= conf_q + 2'(1);
            end
          end
        end
        SFA_INF: begin
          if (at_check && !check_ok) begin
            st_q <= SFA_ERR;
          end
        end
        SFA_ERR: begin
          if (at_check) begin
            st_q <= check_ok ? SFA_INF : SFA_OOF;
          end
        end
        default: st_q <= SFA_OOF;
      endcase
    end
  end

  // descrambler; framing, trace and growth bytes pass in the clear
  assign scr_en = !((row_q == '0) && (col_q < 11'(SFA_SCR_COL)));
  assign seed   = ((row_q == '0) && (col_q == 11'(SFA_SCR_COL))) ?
                  SFA_SEED : lfsr_q;
  assign step   = scr_step(seed);
  assign descr  = (scr_en && !ctrl_in[SFA_CTRL_BYPASS]) ?
                  (aligned ^ step[14:7]) : aligned;
  assign mism   = descr ^ bip_prev_q;
  assign ais    = ctrl_in[SFA_CTRL_FAIS] ||
                  (ctrl_in[SFA_CTRL_AISOOF] && st_q == SFA_OOF);

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      lfsr_q <= SFA_SEED;
    end else if (s_valid && scr_en) begin
      lfsr_q <= step[6:0];
    end
  end

  // parity runs on the scrambled stream; compare needs one whole frame
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      bip_q      <= '0;
      bip_prev_q <= '0;
      seen_q     <= '0;
      b1_err_out <= '0;
    end else if (s_valid) begin
      if (st_q == SFA_OOF) begin
        seen_q <= '0;
      end else if (at_fp) begin
        seen_q <= {seen_q[0], 1'b1};
      end
      if (at_fp) begin
        bip_prev_q <= bip_q;
        bip_q      <= aligned;
      end else begin
        bip_q <= bip_q ^ aligned;
      end
      if (at_b1 && seen_q[1] && st_q != SFA_OOF) begin
        b1_err_out <= (b1_err_out > (SFA_ONES - 8'(ones(mism)))) ?
                      SFA_ONES : b1_err_out + 8'(ones(mism));
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      frm_err_out   <= '0;
      oof_entry_out <= 1'b0;
      oof_out       <= 1'b1;
    end else begin
      oof_entry_out <= s_valid && at_check && !check_ok &&
                       st_q == SFA_ERR;
      oof_out       <= (st_q == SFA_OOF);
      if (s_valid && at_check && !check_ok && st_q == SFA_INF) begin
        frm_err_out <= frm_err_out + 8'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      word_out       <= '0;
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out    <= s_valid;
      word_out.in_frame <= (st_q == SFA_INF);
      word_out.fp       <= s_valid && at_fp && st_q != SFA_OOF;
      word_out.data     <= ais ? SFA_ONES : descr;
    end
  end
endmodule : sfa_chan

module sfa_frame_align
  import sfa_pkg::*;
(
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_n_in,
  input  wire logic [SFA_CH-1:0]          rx_valid_in,
  input  wire logic [SFA_CH-1:0][7:0]     rx_data_in,
  output logic [SFA_CH-1:0]               rx_ready_out,
  input  wire sfa_reg_req_t               reg_req_in,
  output logic [7:0]                      reg_rdata_out,
  input  wire logic                       out_ready_in,
  output sfa_word_t [SFA_CH-1:0]          rx_word_out,
  output logic [SFA_CH-1:0]               rx_valid_out,
  output logic [SFA_CH-1:0]               rx_frame_pulse_out
);
  localparam int LW = $clog2(SFA_FIFO_DEPTH) + 1;
  logic [7:0] thr_min_q, thr_max_q, ctrl_q, ch_en_q, thr_alm_q, oos_alm_q,
              oof_alm_q, live_q, sync_q, oof, oof_entry, cw_valid, f_valid,
              pop, thr_set, oos_set, write_en;
  logic [1:0] mode_q;
  logic       resync;
  sfa_word_t [SFA_CH-1:0] cw, f_data;
  logic [SFA_CH-1:0][7:0] frm_err, b1_err;
  logic [LW-1:0] level [SFA_CH];
  sfa_al_state_t al_q [SFA_CH];
  logic [4:0]    cnt_q [SFA_CH];

  function automatic logic [7:0] members(input logic [1:0] m, input int g);
    logic [7:0] r;
    r = '0;
    case (m)
      SFA_GRP_NONE: r = 8'(1) << g;
      SFA_GRP_PAIR: r = (g < 4) ? (8'h03 << (2 * g)) : '0;
      SFA_GRP_QUAD: r = (g < 2) ? (8'h0F << (4 * g)) : '0;
      SFA_GRP_ALL:  r = (g == 0) ? SFA_ONES : '0;
      default:      r = '0;
    endcase
    return r;
  endfunction : members

  assign resync = reg_req_in.wr && reg_req_in.addr == SFA_OFS_ALIGN &&
                  reg_req_in.wdata[SFA_ALIGN_RESYNC];

  for (genvar c = 0; c < SFA_CH; c++) begin : g_ch
    // source stalls on a full FIFO, which also stalls the framer
    sfa_chan u_chan (
      .clk_sys_in     (clk_sys_in),
      .reset_n_in     (reset_n_in),
      .valid_in       (rx_valid_in[c] & rx_ready_out[c]),
      .data_in        (rx_data_in[c]),
      .ctrl_in        (ctrl_q),
      .word_out       (cw[c]),
      .word_valid_out (cw_valid[c]),
      .oof_out        (oof[c]),
      .oof_entry_out  (oof_entry[c]),
      .frm_err_out    (frm_err[c]),
      .b1_err_out     (b1_err[c])
    );
    // words before the channel's frame pulse are thrown away
    assign write_en[c] = cw_valid[c] && ch_en_q[c] &&
                         (live_q[c] || cw[c].fp);
    sfa_fifo #(
      .W     (SFA_WORD_W),
      .DEPTH (SFA_FIFO_DEPTH)
    ) u_fifo (
      .clk_sys_in    (clk_sys_in),
      .reset_n_in    (reset_n_in),
      .flush_in      (resync),
      .in_valid_in   (write_en[c]),
      .in_data_in    (cw[c]),
      .in_ready_out  (rx_ready_out[c]),
      .out_ready_in  (pop[c]),
      .out_valid_out (f_valid[c]),
      .out_data_out  (f_data[c]),
      .level_out     (level[c])
    );
  end

  // a group reads only when every synced, enabled member has a word
  always_comb begin
    logic [7:0] part;
    part = '0;
    pop  = '0;
    for (int g = 0; g < SFA_CH; g++) begin
      part = members(mode_q, g) & ch_en_q & sync_q;
      if (al_q[g] == SFA_AL_RUN && part != '0 && out_ready_in &&
          ((f_valid & part) == part)) begin
        pop = pop | part;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in || resync) begin
      live_q <= '0;
    end else begin
      live_q <= live_q | (write_en & {cw[7].fp, cw[6].fp, cw[5].fp,
                cw[4].fp, cw[3].fp, cw[2].fp, cw[1].fp, cw[0].fp});
    end
  end

  always_ff @(posedge clk_sys_in) begin
    logic [7:0] act;
    thr_set <= '0;
    oos_set <= '0;
    if (!reset_n_in || resync) begin
      sync_q <= '0;
      for (int g = 0; g < SFA_CH; g++) begin
        al_q[g]  <= SFA_AL_WAIT;
        cnt_q[g] <= '0;
      end
    end else begin
      for (int g = 0; g < SFA_CH; g++) begin
        act = members(mode_q, g) & ch_en_q;
        case (al_q[g])
          SFA_AL_WAIT: begin
            if ((live_q & act) != '0) begin
              cnt_q[g] <= cnt_q[g] + 5'(1);
              if ((live_q & act) == act &&
                  cnt_q[g] >= 5'(SFA_READ_WAIT - 1)) begin
                al_q[g] <= SFA_AL_RUN;
                sync_q  <= (sync_q & ~members(mode_q, g)) | act;
              end else if (cnt_q[g] == 5'(SFA_SKEW_MAX)) begin
                al_q[g] <= SFA_AL_OOS;
                oos_set <= oos_set | (act & ~live_q);
              end
            end
          end
          SFA_AL_RUN: begin
            for (int c = 0; c < SFA_CH; c++) begin
              if (act[c] && sync_q[c] &&
                  (level[c] < LW'(thr_min_q) ||
                   level[c] > LW'(thr_max_q))) begin
                thr_set[c] <= 1'b1;
                oos_set[c] <= 1'b1;
              end
            end
          end
          SFA_AL_OOS: al_q[g] <= SFA_AL_OOS;
          default:    al_q[g] <= SFA_AL_WAIT;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rx_word_out        <= '0;
      rx_valid_out       <= '0;
      rx_frame_pulse_out <= '0;
    end else begin
      rx_valid_out <= pop;
      for (int c = 0; c < SFA_CH; c++) begin
        rx_frame_pulse_out[c] <= pop[c] && f_data[c].fp;
        if (pop[c]) begin
          rx_word_out[c] <= f_data[c];
        end
      end
    end
  end

  // control registers
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      thr_min_q <= SFA_THR_MIN_RST;
      thr_max_q <= SFA_THR_MAX_RST;
      ctrl_q    <= SFA_CTRL_RST;
      ch_en_q   <= SFA_CH_EN_RST;
      mode_q    <= SFA_GRP_NONE;
    end else if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        SFA_OFS_THR_MIN: thr_min_q <= reg_req_in.wdata;
        SFA_OFS_THR_MAX: thr_max_q <= reg_req_in.wdata;
        SFA_OFS_CTRL:    ctrl_q    <= reg_req_in.wdata;
        SFA_OFS_CH_EN:   ch_en_q   <= reg_req_in.wdata;
        SFA_OFS_ALIGN:   mode_q    <= reg_req_in.wdata[1:0];
        default:         mode_q    <= mode_q;
      endcase
    end
  end

  // sticky alarms, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      thr_alm_q <= '0;
      oos_alm_q <= '0;
      oof_alm_q <= '0;
    end else begin
      thr_alm_q <= (thr_alm_q & ~((reg_req_in.wr &&
                   reg_req_in.addr == SFA_OFS_THR_ALM) ? reg_req_in.wdata
                   : '0)) | (thr_set & ch_en_q);
      oos_alm_q <= (oos_alm_q & ~((reg_req_in.wr &&
                   reg_req_in.addr == SFA_OFS_OOS_ALM) ? reg_req_in.wdata
                   : '0)) | (oos_set & ch_en_q);
      oof_alm_q <= (oof_alm_q & ~((reg_req_in.wr &&
                   reg_req_in.addr == SFA_OFS_OOF_ALM) ? reg_req_in.wdata
                   : '0)) | (oof_entry & ch_en_q);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= '0;
      case (reg_req_in.addr)
        SFA_OFS_THR_MIN:  reg_rdata_out <= thr_min_q;
        SFA_OFS_THR_MAX:  reg_rdata_out <= thr_max_q;
        SFA_OFS_CTRL:     reg_rdata_out <= ctrl_q;
        SFA_OFS_ALIGN:    reg_rdata_out <= {6'h00, mode_q};
        SFA_OFS_CH_EN:    reg_rdata_out <= ch_en_q;
        SFA_OFS_OOF_STAT: reg_rdata_out <= oof;
        SFA_OFS_THR_ALM:  reg_rdata_out <= thr_alm_q;
        SFA_OFS_OOS_ALM:  reg_rdata_out <= oos_alm_q;
        SFA_OFS_OOF_ALM:  reg_rdata_out <= oof_alm_q;
        default: begin
          for (int c = 0; c < SFA_CH; c++) begin
            if (reg_req_in.addr == SFA_OFS_FRM_ERR + 20'(c)) begin
              reg_rdata_out <= frm_err[c];
            end
            if (reg_req_in.addr == SFA_OFS_B1_ERR + 20'(c)) begin
              reg_rdata_out <= b1_err[c];
            end
          end
        end
      endcase
    end
  end
endmodule : sfa_frame_align

// File: sfa_frame_align_asserts.sv
module sfa_chk
  import sfa_pkg::*;
(
  input wire logic                   clk_sys_in,
  input wire logic                   reset_n_in,
  input wire logic [SFA_CH-1:0]      rx_valid_in,
  input wire logic [SFA_CH-1:0][7:0] rx_data_in,
  input wire logic [SFA_CH-1:0]      rx_ready_out,
  input wire sfa_reg_req_t           reg_req_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   out_ready_in,
  input wire sfa_word_t [SFA_CH-1:0] rx_word_out,
  input wire logic [SFA_CH-1:0]      rx_valid_out,
  input wire logic [SFA_CH-1:0]      rx_frame_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] thr_min_q, thr_max_q, ctrl_q, grp_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // shadow of the writable registers except channel enable, seen only through the request port
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      thr_min_q <= SFA_THR_MIN_RST;
      thr_max_q <= SFA_THR_MAX_RST;
      ctrl_q    <= SFA_CTRL_RST;
      grp_q     <= 8'h00;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == SFA_OFS_THR_MIN) thr_min_q <= reg_req_in.wdata;
      if (reg_req_in.addr == SFA_OFS_THR_MAX) thr_max_q <= reg_req_in.wdata;
      if (reg_req_in.addr == SFA_OFS_CTRL) ctrl_q <= reg_req_in.wdata;
      if (reg_req_in.addr == SFA_OFS_ALIGN) grp_q <= reg_req_in.wdata;
    end
  end

  reset_quiet_a:
    assert property (disable iff (1'b0) !reset_n_in |=>
      rx_valid_out == '0 && rx_ready_out == '0) else $error("busy in reset");
  ready_release_a:
    assert property (disable iff (1'b0) $rose(reset_n_in) |=>
      rx_ready_out == '1) else $error("fifo not ready after reset");
  fp_valid_a:
    assert property ((rx_frame_pulse_out & ~rx_valid_out) == '0)
      else $error("frame pulse without word");
  fp_first_a1_a:
    assert property (rx_frame_pulse_out[0] && rx_word_out[0].in_frame &&
      !ctrl_q[SFA_CTRL_FAIS] |-> rx_word_out[0].data == SFA_A1)
      else $error("frame pulse not on first A1");
  group_fp_a:
    assert property (grp_q[1:0] == 2'b11 && rx_frame_pulse_out != '0 |->
      rx_frame_pulse_out == '1) else $error("group not aligned");
  thr_min_rd_a:
    assert property (reg_req_in.rd && reg_req_in.addr == SFA_OFS_THR_MIN
      |=> reg_rdata_out == $past(thr_min_q)) else $error("bad min read");
  thr_max_rd_a:
    assert property (reg_req_in.rd && reg_req_in.addr == SFA_OFS_THR_MAX
      |=> reg_rdata_out == $past(thr_max_q)) else $error("bad max read");
  ctrl_rd_a:
    assert property (reg_req_in.rd && reg_req_in.addr == SFA_OFS_CTRL
      |=> reg_rdata_out == $past(ctrl_q)) else $error("bad ctrl read");
  unmapped_zero_a:
    assert property (reg_req_in.rd && reg_req_in.addr < SFA_OFS_THR_MIN
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
      else $error("read data moved without read");
  pop_ready_a:
    assert property (rx_valid_out != '0 |-> $past(out_ready_in))
      else $error("pop while fabric stalled");

  cover property (rx_frame_pulse_out == '1);
  cover property (rx_ready_out == '0);
  cover property (reg_req_in.rd && reg_req_in.addr == SFA_OFS_OOF_ALM);
endmodule : sfa_chk

bind sfa_frame_align sfa_chk i_chk (.clk_sys_in, .reset_n_in, .rx_valid_in,
  .rx_data_in, .rx_ready_out, .reg_req_in, .reg_rdata_out, .out_ready_in,
  .rx_word_out, .rx_valid_out, .rx_frame_pulse_out);

// File: sfa_far_end.sv
module sfa_far_end
  import sfa_pkg::*;
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   corrupt_in,
  input  wire logic [SFA_CH-1:0]      ready_in,
  output logic [SFA_CH-1:0]           valid_out,
  output logic [SFA_CH-1:0][7:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLEN = SFA_COLS * SFA_ROWS;
  logic [13:0] pos_q [SFA_CH];

  assign valid_out = '1;

  // byte held until taken; channels start one byte apart to make skew
  always_ff @(posedge clk_sys_in) begin
    for (int c = 0; c < SFA_CH; c++) begin
      if (!reset_n_in) pos_q[c] <= 14'(c);
      else if (ready_in[c])
        pos_q[c] <= (pos_q[c] == 14'(FLEN - 1)) ? 14'h0000 : pos_q[c] + 14'h0001;
    end
  end

  // filler keeps high nibble zero so no false A1/A2 at any bit offset
  always_comb begin
    for (int c = 0; c < SFA_CH; c++) begin
      if (pos_q[c] < SFA_A1_N) data_out[c] = SFA_A1;
      else if (pos_q[c] < 2 * SFA_A1_N) data_out[c] = corrupt_in ? 8'h00 : SFA_A2;
      else data_out[c] = {4'h0, pos_q[c][3:0]};
    end
  end
endmodule : sfa_far_end

// File: sfa_frame_align_test.sv
module sfa_frame_align_test
  import sfa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLEN = SFA_COLS * SFA_ROWS;
  logic                   clk_sys_in = 1'b0;
  logic                   reset_n_in = 1'b0;
  logic                   out_ready  = 1'b1;
  logic                   corrupt    = 1'b0;
  sfa_reg_req_t           reg_req    = '0;
  logic [SFA_CH-1:0]      rx_valid, rx_ready, v_out, fp_out;
  logic [SFA_CH-1:0][7:0] rx_data;
  logic [7:0]             rdata;
  sfa_word_t [SFA_CH-1:0] word;
  int                     n_errors = 0;
  int                     check_count = 0;
  int                     cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  sfa_far_end i_far (.clk_sys_in, .reset_n_in, .corrupt_in(corrupt),
    .ready_in(rx_ready), .valid_out(rx_valid), .data_out(rx_data));
  sfa_frame_align i_dut (.clk_sys_in, .reset_n_in, .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_ready_out(rx_ready), .reg_req_in(reg_req),
    .reg_rdata_out(rdata), .out_ready_in(out_ready), .rx_word_out(word),
    .rx_valid_out(v_out), .rx_frame_pulse_out(fp_out));

  task automatic complete_run;
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_op(input logic w, input logic [19:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_req <= '{w, !w, a, d};
    @(posedge clk_sys_in);
    reg_req <= '0;
    #1;
  endtask : reg_op

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    reg_op(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask : rd

  task automatic wait_pop(input logic fp);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end while (((fp ? fp_out[0] : v_out[0]) !== 1'b1) && n < 2 * FLEN);
  endtask : wait_pop

  task automatic t_regs;
    rd(SFA_OFS_THR_MIN, SFA_THR_MIN_RST);
    rd(SFA_OFS_THR_MAX, SFA_THR_MAX_RST);
    rd(SFA_OFS_CTRL, SFA_CTRL_RST);
    rd(20'h30001, 8'h00);
    reg_op(1'b1, SFA_OFS_THR_MIN, 8'h05);
    rd(SFA_OFS_THR_MIN, 8'h05);
    reg_op(1'b1, SFA_OFS_THR_MIN, SFA_THR_MIN_RST);
    reg_op(1'b1, SFA_OFS_CTRL, 8'h02);
  endtask : t_regs

  // after two frames the framer may only be confirming, not in frame
  task automatic t_frame;
    repeat (2 * FLEN + 500) @(posedge clk_sys_in);
    rd(SFA_OFS_OOF_STAT, 8'h00);
    chk({7'h0, word[0].in_frame}, 8'h00);
    for (int i = 0; i < 60 && word[0].in_frame !== 1'b1; i++) begin
      repeat (500) @(posedge clk_sys_in);
      reg_op(1'b0, SFA_OFS_OOF_STAT, 8'h00);
    end
    chk({7'h0, word[0].in_frame}, 8'h01);
    rd(SFA_OFS_FRM_ERR, 8'h00);
  endtask : t_frame

  task automatic t_align;
    reg_op(1'b1, SFA_OFS_ALIGN, 8'h07);
    wait_pop(1'b1);
    chk(fp_out, 8'hFF);
    chk(word[0].data, SFA_A1);
    chk({7'h0, word[7].in_frame}, 8'h01);
    rd(SFA_OFS_THR_ALM, 8'h00);
  endtask : t_align

  task automatic t_stall;
    @(posedge clk_sys_in);
    out_ready <= 1'b0;
    repeat (40) @(posedge clk_sys_in);
    #1;
    chk(rx_ready, 8'h00);
    @(posedge clk_sys_in);
    out_ready <= 1'b1;
    rd(SFA_OFS_THR_ALM, 8'hFF);
    rd(SFA_OFS_OOS_ALM, 8'hFF);
  endtask : t_stall

  task automatic t_ais;
    reg_op(1'b1, SFA_OFS_CTRL, 8'h06);
    repeat (100) @(posedge clk_sys_in);
    wait_pop(1'b0);
    chk(word[0].data, SFA_ONES);
    reg_op(1'b1, SFA_OFS_CTRL, 8'h02);
  endtask : t_ais

  // corruption spans exactly two A2 positions of every channel
  task automatic t_loss;
    rd(SFA_OFS_OOF_ALM, 8'h00);
    wait_pop(1'b1);
    @(posedge clk_sys_in);
    corrupt <= 1'b1;
    repeat (2 * FLEN) @(posedge clk_sys_in);
    corrupt <= 1'b0;
    rd(SFA_OFS_OOF_STAT, 8'hFF);
    rd(SFA_OFS_OOF_ALM, 8'hFF);
    rd(SFA_OFS_FRM_ERR, 8'h01);
  endtask : t_loss

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_frame();
    t_align();
    t_stall();
    t_ais();
    t_loss();
    complete_run();
  end
endmodule : sfa_frame_align_test
